/* sbc_spi_slave_port.sv */
// serial slave port: link-side shifters, frame checking, word fifo
`timescale 1ns/1ps
`default_nettype none
`include "sbc_spi_consts.svh"

// How it works
// RULE_01: sixteen-bit word shifted in on master clock
// RULE_02: output word returned in same transfer
// RULE_03: transfer only while chip select held low
// RULE_04: word used only after chip select rises
// RULE_05: output released to high impedance when deselected
// RULE_06: input sampled on every falling clock edge
// RULE_07: output advances after every rising clock edge
// RULE_08: no daisy chain; input never echoed out
// RULE_09: length not zero or sixteen: discard, flag error
// RULE_10: address bits six-zero, mode bit seven, data high
// RULE_11: pending error shown before first rising edge
// RULE_12: new settings visible only after chip select
// RULE_13: chip select synchronised before edge detection
// RULE_14: least significant bit first on both lines
module sbc_spi_slave_port #(
    parameter int FIFO_DEPTH = `SBC_FIFO_DEPTH
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      spi_clk,
    input  wire logic                      chip_select_n,
    input  wire logic                      serial_in,
    output var  logic                      serial_out,
    output var  logic                      serial_out_oe,
    input  wire logic [`SBC_STAT_W-1:0]    status_in,
    output var  logic [`SBC_WORD_BITS-1:0] rx_word,
    output var  logic [`SBC_ADDR_MSB:0]    rx_addr,
    output var  logic                      rx_mode,
    output var  logic [7:0]                rx_data,
    output var  logic                      rx_valid,
    input  wire logic                      rx_ready,
    output var  logic                      frame_err
);

    // ========================================================
    // elaboration check
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("fifo depth below two cannot buffer a word");
    end

    // ========================================================
    // link reset: core reset carried onto the link clock
    logic lrst_s1_r;
    logic lrst_s2_r;

    // needs a few link clock edges while rst_n is low
    always_ff @(negedge spi_clk) begin
        lrst_s1_r <= rst_n;
        lrst_s2_r <= lrst_s1_r;
    end

    // ========================================================
    // link side, falling edge: input shifter and bit counter
    sbc_spi_pkg::sbc_word_t shift_r;
    sbc_spi_pkg::sbc_word_t shift_nxt;
    sbc_spi_pkg::sbc_cnt_t  neg_cnt_r;
    sbc_spi_pkg::sbc_cnt_t  neg_cnt_nxt;

    // counters run free; the core subtracts a per-frame base, so no
    // clock edge is needed to clear them at frame start
    always_comb begin
        shift_nxt   = shift_r;
        neg_cnt_nxt = neg_cnt_r;
        // link reset only bites while deselected: its release needs
        // edges, and the first frame must not lose its leading bits
        if (!chip_select_n) begin                            // RULE_03
            shift_nxt   = {serial_in, shift_r[`SBC_WORD_BITS-1:1]}; // RULE_14
            neg_cnt_nxt = neg_cnt_r + 8'h01;                 // RULE_09
        end else if (!lrst_s2_r) begin
            neg_cnt_nxt = '0;
        end
    end

    always_ff @(negedge spi_clk) begin               // RULE_01 RULE_06
        shift_r   <= shift_nxt;
        neg_cnt_r <= neg_cnt_nxt;
    end

    // ========================================================
    // link side, rising edge: output bit pointer
    sbc_spi_pkg::sbc_cnt_t pos_cnt_r;
    sbc_spi_pkg::sbc_cnt_t pos_cnt_nxt;

    always_comb begin
        pos_cnt_nxt = pos_cnt_r;
        if (!chip_select_n) begin
            pos_cnt_nxt = pos_cnt_r + 8'h01;                 // RULE_07
        end else if (!lrst_s2_r) begin
            pos_cnt_nxt = '0;
        end
    end

    always_ff @(posedge spi_clk) begin
        pos_cnt_r <= pos_cnt_nxt;
    end

    // ========================================================
    // chip select into the core clock
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic frame_start;
    logic frame_end;

    always_ff @(posedge core_clk) begin                      // RULE_13
        if (!rst_n) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= chip_select_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    assign frame_start = !cs_s2_r && cs_s3_r;
    assign frame_end   = cs_s2_r && !cs_s3_r;                // RULE_04

    // ========================================================
    // frame tracker and word capture
    sbc_stream_if #(.W(`SBC_WORD_BITS)) push_if ();
    sbc_stream_if #(.W(`SBC_WORD_BITS)) pop_if ();

    sbc_spi_pkg::sbc_state_t state_r;
    sbc_spi_pkg::sbc_state_t state_nxt;
    sbc_spi_pkg::sbc_cnt_t   neg_base_r;
    sbc_spi_pkg::sbc_cnt_t   neg_base_nxt;
    sbc_spi_pkg::sbc_cnt_t   pos_base_r;
    sbc_spi_pkg::sbc_cnt_t   pos_base_nxt;
    sbc_spi_pkg::sbc_cnt_t   bits;
    sbc_spi_pkg::sbc_word_t  word_r;
    sbc_spi_pkg::sbc_word_t  word_nxt;
    sbc_spi_pkg::sbc_word_t  tx_word_r;
    sbc_spi_pkg::sbc_word_t  tx_word_nxt;
    logic                    pend_r;
    logic                    pend_nxt;
    logic                    err_r;
    logic                    err_nxt;
    logic                    pend_stuck;

    // link counters are read only in done, when the link clock is idle
    // behind a raised chip select, so the multi-bit read is quasi-static
    assign bits       = neg_cnt_r - neg_base_r;
    assign pend_stuck = pend_r && !push_if.ready;

    always_comb begin
        state_nxt    = state_r;
        neg_base_nxt = neg_base_r;
        pos_base_nxt = pos_base_r;
        word_nxt     = word_r;
        tx_word_nxt  = tx_word_r;
        pend_nxt     = pend_r && !push_if.ready;
        err_nxt      = err_r;
        unique case (state_r)
            sbc_spi_pkg::SBC_IDLE: begin
                if (frame_start) begin
                    state_nxt = sbc_spi_pkg::SBC_ACTIVE;
                end
            end
            sbc_spi_pkg::SBC_ACTIVE: begin
                if (frame_end) begin
                    state_nxt = sbc_spi_pkg::SBC_DONE;
                end
            end
            sbc_spi_pkg::SBC_DONE: begin
                state_nxt    = sbc_spi_pkg::SBC_IDLE;
                neg_base_nxt = neg_cnt_r;
                pos_base_nxt = pos_cnt_r;
                // the flag was shown in this frame; a new fault sets it
                // again in the same cycle, so the set wins
                err_nxt = 1'b0;
                if (sbc_spi_pkg::sbc_len_bad(bits)) begin
                    err_nxt = 1'b1;                          // RULE_09
                end else if (bits == `SBC_BITS_OK) begin
                    if (pend_stuck) begin
                        // fifo full: drop the word rather than stall
                        // a master that cannot be held off
                        err_nxt = 1'b1;
                    end else begin
                        word_nxt = shift_r;                  // RULE_04
                        pend_nxt = 1'b1;                     // RULE_12
                    end
                end
                tx_word_nxt = {status_in, err_nxt};          // RULE_11
            end
            default: begin
                state_nxt = sbc_spi_pkg::SBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r    <= sbc_spi_pkg::SBC_IDLE;
            neg_base_r <= '0;
            pos_base_r <= '0;
            word_r     <= '0;
            tx_word_r  <= '0;
            pend_r     <= 1'b0;
            err_r      <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            neg_base_r <= neg_base_nxt;
            pos_base_r <= pos_base_nxt;
            word_r     <= word_nxt;
            tx_word_r  <= tx_word_nxt;
            pend_r     <= pend_nxt;
            err_r      <= err_nxt;
        end
    end

    // ========================================================
    // serial output: bit index follows the rising edges of this frame
    sbc_spi_pkg::sbc_cnt_t out_idx;

    // tx_word_r and pos_base_r only move in done, never mid-frame
    assign out_idx = pos_cnt_r - pos_base_r;

    always_comb begin
        serial_out = 1'b0;
        if (out_idx < `SBC_BITS_OK) begin
            // bit zero, the error flag, stands before the first rise;
            // serial_in never reaches this path
            serial_out = tx_word_r[out_idx[`SBC_IDX_W-1:0]]; // RULE_02 RULE_08
        end
        serial_out_oe = !chip_select_n;                      // RULE_05
    end

    // ========================================================
    // fifo towards the user
    assign push_if.valid = pend_r;
    assign push_if.data  = word_r;
    assign pop_if.ready  = rx_ready;

    sbc_fifo #(
        .W     (`SBC_WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr       (push_if),
        .rd       (pop_if)
    );

    always_comb begin
        rx_word   = pop_if.data;
        rx_addr   = sbc_spi_pkg::sbc_word_addr(pop_if.data);  // RULE_10
        rx_mode   = pop_if.data[`SBC_RW_BIT];
        rx_data   = sbc_spi_pkg::sbc_word_data(pop_if.data);
        rx_valid  = pop_if.valid;
        frame_err = err_r;
    end

    // ========================================================
    // checks
    chk_bad_len_err: assert property (                       // RULE_09
        @(posedge core_clk) disable iff (!rst_n)
        state_r == sbc_spi_pkg::SBC_DONE && bits != 8'h00 && bits != 8'h10
        |=> err_r && tx_word_r[0])
        else $error("bad frame length did not raise the error flag");

    chk_bad_len_drop: assert property (                      // RULE_09
        @(posedge core_clk) disable iff (!rst_n)
        state_r == sbc_spi_pkg::SBC_DONE && bits != 8'h10
        |=> $stable(word_r))
        else $error("word captured from a frame of wrong length");

    chk_good_capture: assert property (                      // RULE_01
        @(posedge core_clk) disable iff (!rst_n)
        state_r == sbc_spi_pkg::SBC_DONE && bits == 8'h10 && !pend_stuck
        |=> pend_r && word_r == $past(shift_r))
        else $error("sixteen-bit frame not captured");

    chk_after_release: assert property (                     // RULE_04
        @(posedge core_clk) disable iff (!rst_n)
        $rose(pend_r) |-> $past(state_r) == sbc_spi_pkg::SBC_DONE
                          && $past(cs_s2_r, 2))
        else $error("word handed on before chip select rose");

    chk_end_path: assert property (                          // RULE_04
        @(posedge core_clk) disable iff (!rst_n)
        state_r == sbc_spi_pkg::SBC_ACTIVE && frame_end
        |=> state_r == sbc_spi_pkg::SBC_DONE
            ##1 state_r == sbc_spi_pkg::SBC_IDLE)
        else $error("frame end not followed by done then idle");

    chk_release_out: assert property (                       // RULE_05
        @(posedge core_clk) disable iff (!rst_n)
        chip_select_n |-> !serial_out_oe)
        else $error("serial output driven while deselected");

    chk_tx_frozen: assert property (                         // RULE_12
        @(posedge core_clk) disable iff (!rst_n)
        state_r == sbc_spi_pkg::SBC_ACTIVE
        |-> $stable(tx_word_r) && $stable(pos_base_r))
        else $error("output word changed during a frame");

    chk_err_bit: assert property (                           // RULE_11
        @(posedge core_clk) disable iff (!rst_n)
        state_r != sbc_spi_pkg::SBC_DONE |-> tx_word_r[0] == err_r)
        else $error("error bit of output word disagrees with flag");

    chk_bit_count: assert property (                         // RULE_06
        @(negedge spi_clk) disable iff (!lrst_s2_r)
        !chip_select_n |=> neg_cnt_r == $past(neg_cnt_r) + 8'h01)
        else $error("falling edge not counted during a frame");

endmodule : sbc_spi_slave_port

`default_nettype wire

/* sbc_spi_consts.svh */
// constants for the serial slave port: word layout, counts, state codes
`ifndef SBC_SPI_CONSTS_SVH
`define SBC_SPI_CONSTS_SVH

// ============================================================
// word layout
`define SBC_WORD_BITS   16
`define SBC_IDX_W       4
`define SBC_ADDR_MSB    6
`define SBC_ADDR_LSB    0
`define SBC_RW_BIT      7
`define SBC_DATA_MSB    15
`define SBC_DATA_LSB    8
`define SBC_ERR_BIT     0
`define SBC_STAT_W      15

// ============================================================
// counts and depths
`define SBC_CNT_W       8
`define SBC_BITS_OK     8'h10
`define SBC_BITS_NONE   8'h00
`define SBC_FIFO_DEPTH  16

// ============================================================
// state codes, gray along idle -> active -> done; done -> idle flips both bits
`define SBC_ST_IDLE     2'h0
`define SBC_ST_ACTIVE   2'h1
`define SBC_ST_DONE     2'h3

`endif

/* sbc_spi_pkg.sv */
// types and word decode helpers for the serial slave port
`default_nettype none
`include "sbc_spi_consts.svh"

package sbc_spi_pkg;

    // ========================================================
    // types
    typedef logic [`SBC_WORD_BITS-1:0] sbc_word_t;
    typedef logic [`SBC_CNT_W-1:0]     sbc_cnt_t;

    typedef enum logic [1:0] {
        SBC_IDLE   = `SBC_ST_IDLE,
        SBC_ACTIVE = `SBC_ST_ACTIVE,
        SBC_DONE   = `SBC_ST_DONE
    } sbc_state_t;

    // ========================================================
    // field decode
    function automatic logic [`SBC_ADDR_MSB:0] sbc_word_addr(
        input sbc_word_t w);
        return w[`SBC_ADDR_MSB:`SBC_ADDR_LSB];
    endfunction : sbc_word_addr

    function automatic logic [7:0] sbc_word_data(input sbc_word_t w);
        return w[`SBC_DATA_MSB:`SBC_DATA_LSB];
    endfunction : sbc_word_data

    // transfer length is legal when it is zero or one whole word
    function automatic logic sbc_len_bad(input sbc_cnt_t n);
        return (n != `SBC_BITS_NONE) && (n != `SBC_BITS_OK);
    endfunction : sbc_len_bad

endpackage : sbc_spi_pkg

`default_nettype wire

/* sbc_stream_if.sv */
// valid/ready word stream between the port core and its fifo
`timescale 1ns/1ps
`default_nettype none

interface sbc_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : sbc_stream_if

`default_nettype wire

/* sbc_fifo.sv */
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sbc_spi_consts.svh"

module sbc_fifo #(
    parameter int W     = `SBC_WORD_BITS,
    parameter int DEPTH = `SBC_FIFO_DEPTH
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    sbc_stream_if.dst wr,
    sbc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    // ========================================================
    // elaboration check
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sbc_fifo depth must be a power of two of at least two");
    end

    // ========================================================
    // storage and pointers
    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wp_r;
    logic [AW:0]  wp_nxt;
    logic [AW:0]  rp_r;
    logic [AW:0]  rp_nxt;
    logic         full;
    logic         empty;
    logic         do_wr;
    logic         do_rd;

    assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty    = (wp_r == rp_r);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem_r[rp_r[AW-1:0]];

    always_comb begin
        do_wr  = wr.valid && !full;
        do_rd  = rd.ready && !empty;
        wp_nxt = wp_r + (AW+1)'(do_wr);
        rp_nxt = rp_r + (AW+1)'(do_rd);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // memory has no reset; only written slots are ever read
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem_r[wp_r[AW-1:0]] <= wr.data;
        end
    end

    chk_no_push_full: assert property (@(posedge core_clk) disable iff (!rst_n)
        full && !do_rd |=> $stable(wp_r))
        else $error("fifo pointer moved while full");

endmodule : sbc_fifo

`default_nettype wire

/* sbc_spi_master_model.sv */
// microcontroller model: serial bus master facing the slave port
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_master_model #(
    parameter int HALF = 3
) (
    output var  logic spi_clk,
    output var  logic chip_select_n,
    output var  logic serial_in,
    input  wire logic so_line
);
    initial begin
        spi_clk       = 1'b0;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
    end

    // ============================================================
    // link reset pulses, only while chip select stays high
    task automatic link_pulses(input int n);
        repeat (n) begin
            #HALF spi_clk = 1'b1;
            #HALF spi_clk = 1'b0;
        end
    endtask : link_pulses

    // ============================================================
    // one frame, lsb first; clock parked low at both select edges
    task automatic xfer(input int nbits, input logic [15:0] w,
                        output logic [15:0] rd);
        rd = 16'h0000;
        chip_select_n = 1'b0;
        #HALF rd[0] = so_line;
        for (int i = 0; i < nbits; i++) begin
            // data moves on the rising edge, clear of the sampling edge
            #HALF spi_clk = 1'b1;
            serial_in = w[i % 16];
            #HALF if (i < 15) rd[i+1] = so_line;
            spi_clk = 1'b0;
        end
        #HALF chip_select_n = 1'b1;
        // a released line must not look like it still holds data
        serial_in = ~serial_in;
    endtask : xfer
endmodule : sbc_spi_master_model

`default_nettype wire

/* sbc_spi_slave_port_tb.sv */
// self-checking bench for the serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "sbc_spi_consts.svh"

module sbc_spi_slave_port_tb;
    localparam int DEPTH = 16;
    logic                      core_clk;
    logic                      rst_n;
    logic                      spi_clk;
    logic                      chip_select_n;
    logic                      serial_in;
    logic                      serial_out;
    logic                      serial_out_oe;
    logic [`SBC_STAT_W-1:0]    status_in;
    logic [`SBC_WORD_BITS-1:0] rx_word;
    logic [`SBC_ADDR_MSB:0]    rx_addr;
    logic                      rx_mode;
    logic [7:0]                rx_data;
    logic                      rx_valid;
    logic                      rx_ready;
    logic                      frame_err;
    wire                       so_line;
    int                        miscompares;
    int                        check_count;
    logic [15:0]               rd;

    assign so_line = serial_out_oe ? serial_out : 1'bz;

    sbc_spi_slave_port #(.FIFO_DEPTH(DEPTH)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .status_in(status_in), .rx_word(rx_word), .rx_addr(rx_addr),
        .rx_mode(rx_mode), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .frame_err(frame_err)
    );

    sbc_spi_master_model u_master (
        .spi_clk(spi_clk), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .so_line(so_line)
    );

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // ============================================================
    // helpers
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles

    // frame, then line released, then the idle gap between frames
    task automatic frame(input int n, input logic [15:0] w);
        u_master.xfer(n, w, rd);
        #1;
        chk16({15'h0, serial_out_oe}, 16'h0000);
        chk16({15'h0, so_line}, {15'h0, 1'bz});
        cycles(4);
    endtask : frame

    // bounded wait for the head word, compare fields, pop it
    task automatic take(input logic [15:0] exp);
        int n;
        n = 0;
        do begin
            cycles(1);
            n++;
        end while (rx_valid !== 1'b1 && n < 20);
        chk16(rx_word, exp);
        chk16({9'h0, rx_addr}, {9'h0, exp[6:0]});
        chk16({15'h0, rx_mode}, {15'h0, exp[7]});
        chk16({8'h0, rx_data}, {8'h0, exp[15:8]});
        rx_ready = 1'b1;
        cycles(1);
        rx_ready = 1'b0;
    endtask : take

    // ============================================================
    // scenarios
    task automatic t_basic;
        u_master.xfer(16, 16'hb2c5, rd);
        chk16(rd, 16'h0000);
        chk16({15'h0, rx_valid}, 16'h0000);
        take(16'hb2c5);
        frame(16, 16'h4e81);
        chk16(rd, {status_in, 1'b0});
        take(16'h4e81);
        $display("test basic done");
    endtask : t_basic

    task automatic t_errors;
        int lens [3] = '{1, 15, 17};
        foreach (lens[k]) begin
            frame(lens[k], 16'h3c3c);
            cycles(10);
            chk16({15'h0, frame_err}, 16'h0001);
            chk16({15'h0, rx_valid}, 16'h0000);
            frame(0, 16'h0000);
            chk16({15'h0, rd[0]}, 16'h0001);
            cycles(10);
            chk16({15'h0, frame_err}, 16'h0000);
        end
        frame(7, 16'h0000);
        frame(16, 16'h9a17);
        chk16({15'h0, rd[0]}, 16'h0001);
        take(16'h9a17);
        chk16({15'h0, frame_err}, 16'h0000);
        $display("test errors done");
    endtask : t_errors

    task automatic t_overflow;
        // status changes between frames, so the frame after next is the first to show it
        status_in = 15'h0123;
        // one word waits beside the full fifo, so depth plus one fit
        for (int i = 0; i <= DEPTH; i++) frame(16, 16'h0f00 + 16'(i * 9));
        frame(16, 16'hdead);
        cycles(10);
        chk16({15'h0, frame_err}, 16'h0001);
        for (int i = 0; i <= DEPTH; i++) take(16'h0f00 + 16'(i * 9));
        cycles(2);
        chk16({15'h0, rx_valid}, 16'h0000);
        frame(16, 16'h5501);
        chk16(rd, {15'h0123, 1'b1});
        take(16'h5501);
        $display("test overflow done");
    endtask : t_overflow

    // ============================================================
    // verdict
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #100000;
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        miscompares = 0;
        check_count = 0;
        rst_n       = 1'b0;
        rx_ready    = 1'b0;
        status_in   = 15'h2d5a;
        // link counters need falling edges while reset is low
        fork
            u_master.link_pulses(4);
            repeat (5) @(posedge core_clk);
        join
        cycles(1);
        rst_n = 1'b1;
        chk16({15'h0, frame_err}, 16'h0000);
        chk16({15'h0, rx_valid}, 16'h0000);
        t_basic();
        t_errors();
        t_overflow();
        end_of_test();
    end
endmodule : sbc_spi_slave_port_tb

`default_nettype wire
